// file: src/ram_pkg.sv
// shared constants and types for the embedded synchronous ram block
package ram_pkg;
  // ==========================================================
  // geometry
  localparam int DW = 144;
  localparam int AW = 16;
  localparam int SMALL_WIDTH = 18;
  localparam int SMALL_DEPTH = 32;
  localparam int MEDIUM_WIDTH = 36;
  localparam int MEDIUM_DEPTH = 128;
  localparam int LARGE_WIDTH = 144;
  localparam int LARGE_DEPTH = 4096;
  // filler shown where the read result is undefined
  localparam logic [DW-1:0] UNDEF_WORD = {9{16'hdead}};
  typedef enum logic [1:0] {SZ_SMALL = 2'h0, SZ_MEDIUM = 2'h1, SZ_LARGE = 2'h2} size_t;
  // port arrangement; gray-ordered from single to dual-single
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_SIMPLE = 2'h1,
    MODE_TRUE = 2'h3,
    MODE_DUAL_SINGLE = 2'h2
  } mode_t;
  // ==========================================================
  // register map
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  typedef struct packed {
    logic [2:0] shift_b;
    logic [2:0] shift_a;
    logic flowthru;
    logic rdw_old;
    logic bypass_b;
    logic bypass_a;
    mode_t mode;
  } cfg_t;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam int STAT_RDW_BIT = 0;
  localparam int STAT_CONFLICT_BIT = 1;
  localparam int STAT_SIZE_LSB = 2;
  localparam int STAT_MODE_LSB = 4;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic en;
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } port_req_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// file: src/embedded_sync_ram_block.sv
// embedded synchronous ram block with apb configuration and status
// Overview of operation
// RQ1: the block is built as a small 32x18, medium 128x36 or large 4Kx144 store with selectable aspect ratio.
// RQ2: every size works as single-port, simple dual-port or fifo storage, parity bits included. The block has no fifo mode.
// RQ3: medium and large blocks offer a true dual-port mode with any mix of reads and writes on both ports.
// RQ4: address, write data and controls are captured in input registers so writes are synchronous.
// RQ5: the block makes its own write strobe from the clock; user logic only presents registered controls.
// RQ6: each read port has an output register that can be bypassed, giving data straight after the address register.
// RQ7: simple dual-port allows read and write together; a same-address read gives old data or undefined bits.
// RQ8: single-port never reads and writes together; a written word shows on q at once or after the next edge.
// RQ9: small and medium simple dual-port support flow-through reads, address captured on the falling edge.
// RQ10: a medium block can hold two independent single-port memories, each up to half the capacity.
// RQ11: write and read ports may have different widths over the same storage.
// RQ12: the large block has no preload; as rom it is written once and then the write enables stay low.
// RQ13: small and medium blocks clear input and output registers; the large block clears outputs only.
// RQ14: after reset small and medium outputs read zero while large outputs stay undefined until a read.
// RQ15: on the large block a read hitting the word written by the other port returns undefined data.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module embedded_sync_ram_block #(
  parameter ram_pkg::size_t SIZE = ram_pkg::SZ_MEDIUM
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire ram_pkg::apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ram_pkg::port_req_t port_a_i,
  input wire ram_pkg::port_req_t port_b_i,
  input wire logic inclr_i,
  input wire logic outclr_i,
  output logic [ram_pkg::DW-1:0] q_a_o,
  output logic [ram_pkg::DW-1:0] q_b_o
);
  import ram_pkg::*;

  // ==========================================================
  // geometry of the selected size
  localparam int NW = (SIZE == SZ_SMALL) ? SMALL_WIDTH :
                      (SIZE == SZ_MEDIUM) ? MEDIUM_WIDTH : LARGE_WIDTH; // [RQ1]
  localparam int DEPTH = (SIZE == SZ_SMALL) ? SMALL_DEPTH :
                         (SIZE == SZ_MEDIUM) ? MEDIUM_DEPTH : LARGE_DEPTH;
  localparam int IW = $clog2(DEPTH);
  localparam bit IS_LARGE = (SIZE == SZ_LARGE);
  localparam logic [DW-1:0] Q_RESET = IS_LARGE ? UNDEF_WORD : '0;

  cfg_t cfg;
  logic [1:0] stat_sticky;
  mode_t mode_eff;
  port_req_t ra;
  port_req_t rb;
  logic rb_neg_re;
  logic [AW-1:0] rb_neg_addr;
  logic flow;
  logic single_a;
  logic single_b;
  logic half;
  logic [IW-1:0] ia;
  logic [IW-1:0] ib;
  logic [AW-1:0] b_rd_addr;
  logic b_rd_re;
  logic wr_a;
  logic wr_b;
  logic rd_a;
  logic rd_b;
  logic [IW-1:0] ib_rd;
  logic coll_a;
  logic coll_b;
  logic [DW-1:0] comb_a;
  logic [DW-1:0] comb_b;
  logic [DW-1:0] qa_reg;
  logic [DW-1:0] qb_reg;
  logic apb_take;
  logic apb_done;
  logic [31:0] next_prdata;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;
  // no initial contents anywhere: a rom image must be written by user logic
  logic [NW-1:0] mem [0:DEPTH-1]; // [RQ12]

  // ==========================================================
  // width conversion helpers
  // pick one lane of a stored word; lane width is the native width over 2**shift
  function automatic logic [DW-1:0] get_slice(input logic [NW-1:0] w,
                                              input logic [AW-1:0] a,
                                              input logic [2:0] s);
    int pw;
    int lane;
    logic [DW-1:0] r;
    pw = NW >> s;
    lane = int'(a) & ((1 << s) - 1);
    r = DW'(w >> (lane * pw));
    r = r & ((DW'(1) << pw) - DW'(1));
    return r;
  endfunction

  // merge one lane into a stored word, leaving the other lanes intact
  function automatic logic [NW-1:0] put_slice(input logic [NW-1:0] w,
                                              input logic [AW-1:0] a,
                                              input logic [2:0] s,
                                              input logic [DW-1:0] d);
    int pw;
    int off;
    logic [NW-1:0] m;
    pw = NW >> s;
    off = (int'(a) & ((1 << s) - 1)) * pw;
    m = (NW'(1) << pw) - NW'(1);
    return (w & ~(m << off)) | ((NW'(d) & m) << off);
  endfunction

  // word index; in dual-single mode each port owns one half of the words
  function automatic logic [IW-1:0] word_idx(input logic [AW-1:0] a,
                                             input logic [2:0] s,
                                             input logic hf,
                                             input logic upper);
    logic [IW-1:0] i;
    i = IW'(a >> s);
    if (hf) begin
      i[IW-1] = upper;
    end
    return i;
  endfunction

  // ==========================================================
  // mode legalisation
  // requests the size cannot honour fall back to the nearest supported mode
  always_comb begin
    mode_eff = cfg.mode;
    if (SIZE == SZ_SMALL && (cfg.mode == MODE_TRUE || cfg.mode == MODE_DUAL_SINGLE)) begin
      mode_eff = MODE_SIMPLE; // [RQ3]
    end else if (SIZE == SZ_LARGE && cfg.mode == MODE_DUAL_SINGLE) begin
      mode_eff = MODE_SINGLE; // [RQ10]
    end
  end

  assign single_a = (mode_eff == MODE_SINGLE) || (mode_eff == MODE_DUAL_SINGLE); // [RQ2]
  assign single_b = (mode_eff == MODE_DUAL_SINGLE);
  assign half = (mode_eff == MODE_DUAL_SINGLE); // [RQ10]
  assign flow = cfg.flowthru && !IS_LARGE && (mode_eff == MODE_SIMPLE); // [RQ9]

  // ==========================================================
  // input registers; the large block has no input clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ra <= '0;
      rb <= '0;
    end else if (inclr_i && !IS_LARGE) begin
      ra <= '0; // [RQ13]
      rb <= '0;
    end else begin
      ra <= port_a_i; // [RQ4]
      rb <= port_b_i;
    end
  end

  // falling-edge capture of the read side for flow-through reads
  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rb_neg_re <= 1'b0;
      rb_neg_addr <= '0;
    end else if (inclr_i && !IS_LARGE) begin
      rb_neg_re <= 1'b0;
      rb_neg_addr <= '0;
    end else begin
      rb_neg_re <= port_b_i.en & port_b_i.re; // [RQ9]
      rb_neg_addr <= port_b_i.addr;
    end
  end

  // ==========================================================
  // self-timed write strobes and read qualifiers
  // a write lands on the edge after its request was registered
  assign wr_a = ra.en & ra.we & ~(single_a & ra.re); // [RQ5] [RQ8]
  assign wr_b = rb.en & rb.we & ((mode_eff == MODE_TRUE) | single_b); // [RQ3]
  assign b_rd_addr = flow ? rb_neg_addr : rb.addr;
  assign b_rd_re = flow ? rb_neg_re : (rb.en & rb.re);
  // in single-port use a write also refreshes q with the written word
  assign rd_a = (ra.en & ra.re & (mode_eff != MODE_SIMPLE)) | (single_a & wr_a);
  assign rd_b = (b_rd_re & (mode_eff != MODE_SINGLE)) | (single_b & wr_b);
  assign ia = word_idx(ra.addr, cfg.shift_a, half, 1'b0); // [RQ11]
  assign ib = word_idx(rb.addr, cfg.shift_b, half, 1'b1);
  assign ib_rd = word_idx(b_rd_addr, cfg.shift_b, half, 1'b1);

  // storage write; when both ports hit one word the later port b wins
  always_ff @(posedge clk_i) begin
    if (wr_a) begin
      mem[ia] <= put_slice(mem[ia], ra.addr, cfg.shift_a, ra.wdata); // [RQ5] [RQ11]
    end
    if (wr_b) begin
      mem[ib] <= put_slice(mem[ib], rb.addr, cfg.shift_b, rb.wdata);
    end
  end

  // ==========================================================
  // read paths with mixed-port read-during-write
  assign coll_b = rd_b & wr_a & ~single_b & (ib_rd == ia);
  assign coll_a = rd_a & wr_b & ~single_a & (ia == ib);

  // the array still holds old data before the write edge, so old data is free
  always_comb begin
    comb_a = get_slice(mem[ia], ra.addr, cfg.shift_a);
    if (single_a && wr_a) begin
      comb_a = get_slice(NW'(ra.wdata), ra.addr, cfg.shift_a); // [RQ8]
    end else if (coll_a && (IS_LARGE || !cfg.rdw_old)) begin
      comb_a = UNDEF_WORD; // [RQ15]
    end
  end

  always_comb begin
    comb_b = get_slice(mem[ib_rd], b_rd_addr, cfg.shift_b);
    if (single_b && wr_b) begin
      comb_b = get_slice(NW'(rb.wdata), rb.addr, cfg.shift_b);
    end else if (coll_b && (IS_LARGE || !cfg.rdw_old)) begin
      comb_b = UNDEF_WORD; // [RQ7] [RQ15]
    end
  end

  // output registers; reset shows zero except on the large block
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qa_reg <= Q_RESET; // [RQ14]
      qb_reg <= Q_RESET;
    end else begin
      if (outclr_i) begin
        qa_reg <= Q_RESET; // [RQ13]
      end else if (rd_a) begin
        qa_reg <= comb_a;
      end
      if (outclr_i) begin
        qb_reg <= Q_RESET;
      end else if (rd_b) begin
        qb_reg <= comb_b;
      end
    end
  end

  // bypass trades a cycle of latency for a combinational path to the fabric
  assign q_a_o = cfg.bypass_a ? comb_a : qa_reg; // [RQ6]
  assign q_b_o = (cfg.bypass_b || flow) ? comb_b : qb_reg; // [RQ6] [RQ9]

  // ==========================================================
  // apb slave: one wait state, unmapped addresses answer with pslverr
  assign apb_take = apb_i.psel & apb_i.penable & ~pready_o;
  assign apb_done = apb_i.psel & apb_i.penable & pready_o;

  always_comb begin
    next_prdata = '0;
    if (apb_i.paddr == CFG_ADDR) begin
      next_prdata = {20'h00000, cfg};
    end else if (apb_i.paddr == STAT_ADDR) begin
      next_prdata[STAT_RDW_BIT] = stat_sticky[0];
      next_prdata[STAT_CONFLICT_BIT] = stat_sticky[1];
      next_prdata[STAT_SIZE_LSB +: 2] = SIZE;
      next_prdata[STAT_MODE_LSB +: 2] = mode_eff;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_take;
      if (apb_take) begin
        prdata_o <= apb_i.pwrite ? 32'h00000000 : next_prdata;
        pslverr_o <= (apb_i.paddr != CFG_ADDR) && (apb_i.paddr != STAT_ADDR);
      end
    end
  end

  // configuration register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= cfg_t'(CFG_RESET);
    end else if (apb_done && apb_i.pwrite && apb_i.paddr == CFG_ADDR) begin
      cfg <= cfg_t'(apb_i.pwdata[11:0]);
    end
  end

  // sticky status: write one to clear, a new event wins over the clear
  assign stat_set = {ra.en & ra.we & ra.re & single_a, coll_a | coll_b};
  assign stat_clr = (apb_done && apb_i.pwrite && apb_i.paddr == STAT_ADDR) ?
                    apb_i.pwdata[1:0] : 2'h0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_sticky <= 2'h0;
    end else begin
      stat_sticky <= stat_set | (stat_sticky & ~stat_clr); // [RQ8]
    end
  end

  // ==========================================================
  // assertions
  property p_input_reg;
    @(posedge clk_i) disable iff (!nrst_i)
    !inclr_i |=> (ra == $past(port_a_i)) && (rb == $past(port_b_i));
  endproperty
  a_input_reg: assert property (p_input_reg) else $error("input register missed a request"); // [RQ4]

  property p_write_lands;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_a && !wr_b && cfg.shift_a == 3'h0 && !inclr_i && !outclr_i)
      |=> mem[$past(ia)] == $past(ra.wdata[NW-1:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write strobe did not store data"); // [RQ5]

  property p_out_reg;
    @(posedge clk_i) disable iff (!nrst_i)
    (rd_a && !cfg.bypass_a && !outclr_i) ##1 !$changed(cfg) |-> q_a_o == $past(comb_a);
  endproperty
  a_out_reg: assert property (p_out_reg) else $error("registered read data wrong"); // [RQ6]

  property p_rdw_old;
    @(posedge clk_i) disable iff (!nrst_i)
    (coll_b && cfg.rdw_old && !IS_LARGE)
      |-> comb_b == get_slice(mem[ib_rd], b_rd_addr, cfg.shift_b);
  endproperty
  a_rdw_old: assert property (p_rdw_old) else $error("collision read not old data"); // [RQ7]

  property p_write_through;
    @(posedge clk_i) disable iff (!nrst_i)
    (single_a && wr_a && cfg.bypass_a && cfg.shift_a == 3'h0)
      |-> q_a_o == DW'(ra.wdata[NW-1:0]);
  endproperty
  a_write_through: assert property (p_write_through) else $error("single-port write not shown"); // [RQ8]

  property p_small_no_true;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_b |-> (SIZE != SZ_SMALL) && (mode_eff == MODE_TRUE || mode_eff == MODE_DUAL_SINGLE);
  endproperty
  a_small_no_true: assert property (p_small_no_true) else $error("small block wrote port b"); // [RQ3]

  property p_out_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    outclr_i |=> (qa_reg == Q_RESET) && (qb_reg == Q_RESET);
  endproperty
  a_out_clear: assert property (p_out_clear) else $error("output clear ignored"); // [RQ13]

  property p_in_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    (inclr_i && !IS_LARGE) |=> !ra.en && !rb.en && !wr_a;
  endproperty
  a_in_clear: assert property (p_in_clear) else $error("input clear ignored"); // [RQ13]

  property p_large_undef;
    @(posedge clk_i) disable iff (!nrst_i)
    (coll_b && (IS_LARGE || !cfg.rdw_old)) |-> comb_b == UNDEF_WORD;
  endproperty
  a_large_undef: assert property (p_large_undef) else $error("collision not undefined"); // [RQ7] [RQ15]

  property p_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
    (coll_a || coll_b) |=> stat_sticky[0] ##1 (stat_sticky[0] || $past(stat_clr[0]));
  endproperty
  a_sticky: assert property (p_sticky) else $error("collision flag lost"); // [RQ7]

  c_collision: cover property (@(posedge clk_i) disable iff (!nrst_i) coll_b ##1 coll_a);
  c_flow: cover property (@(posedge clk_i) disable iff (!nrst_i) flow && rd_b);
  c_dual_write: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_a && wr_b);
  c_cfg_write: cover property (@(posedge clk_i) disable iff (!nrst_i)
    apb_done && apb_i.pwrite && apb_i.paddr == CFG_ADDR);

endmodule // embedded_sync_ram_block
`default_nettype wire

// file: bench/fabric_model.sv
// fabric-side user logic that registers port requests before they reach the ram block
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire ram_pkg::port_req_t cmd_a_i,
  input wire ram_pkg::port_req_t cmd_b_i,
  input wire logic hold_i,
  output ram_pkg::port_req_t port_a_o,
  output ram_pkg::port_req_t port_b_o
);
  import ram_pkg::*;
  // =====================================================
  // registered request stage
  // requests leave a flop, so the block never sees a shaped strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_a_o <= '0;
      port_b_o <= '0;
    end else begin
      // a read beside a write is never asked on port a; port b passes re through unmasked
      // rom use: write enables held low once contents are loaded
      port_a_o <= '{en: cmd_a_i.en, we: cmd_a_i.we & ~hold_i, re: cmd_a_i.re & ~cmd_a_i.we,
                    addr: cmd_a_i.addr, wdata: cmd_a_i.wdata};
      port_b_o <= '{en: cmd_b_i.en, we: cmd_b_i.we & ~hold_i, re: cmd_b_i.re,
                    addr: cmd_b_i.addr, wdata: cmd_b_i.wdata};
    end
  end
endmodule // fabric_model
`default_nettype wire

// file: bench/tb.sv
// self-checking testbench for the embedded synchronous ram block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import ram_pkg::*;
  typedef struct packed {logic [15:0] addr; logic [35:0] wd; logic [35:0] exp;} row_t;
  logic clk_i;
  logic nrst_i;
  apb_req_t apb;
  port_req_t cmd_a;
  port_req_t cmd_b;
  port_req_t port_a;
  port_req_t port_b;
  logic hold;
  logic inclr;
  logic outclr;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [DW-1:0] q_a;
  logic [DW-1:0] q_b;
  logic [31:0] rd;
  logic err;
  int miscompares;
  int checks;
  // plain table: write every row, then read every row back
  row_t rows [4] = '{'{16'h0000, 36'h123456789, 36'h123456789},
                     '{16'h007f, 36'hfedcba987, 36'hfedcba987},
                     '{16'h0005, 36'h00000000f, 36'haaaaaaaaa},
                     '{16'h0005, 36'haaaaaaaaa, 36'haaaaaaaaa}};
  // =====================================================
  // clock, reset and instances
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;
  embedded_sync_ram_block #(.SIZE(SZ_MEDIUM)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
    .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port_a_i(port_a), .port_b_i(port_b), .inclr_i(inclr), .outclr_i(outclr),
    .q_a_o(q_a), .q_b_o(q_b));
  fabric_model fab (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_a_i(cmd_a), .cmd_b_i(cmd_b),
    .hold_i(hold), .port_a_o(port_a), .port_b_o(port_b));
  // =====================================================
  // bus and port tasks
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  function automatic port_req_t rq(logic we, logic re, logic [15:0] a, logic [35:0] d);
    rq = {1'b1, we, re, a, 144'(d)};
  endfunction
  // one request pair; the model adds a cycle, the block captures on the next
  task automatic op(input port_req_t a, input port_req_t b, input int n);
    @(posedge clk_i);
    cmd_a <= a;
    cmd_b <= b;
    @(posedge clk_i);
    cmd_a <= '0;
    cmd_b <= '0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  // =====================================================
  // main sequence
  initial begin
    apb = '0;
    cmd_a = '0;
    cmd_b = '0;
    hold = 1'b0;
    inclr = 1'b0;
    outclr = 1'b0;
    miscompares = 0;
    checks = 0;
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    `CHK(q_a[35:0], 36'h0)
    `CHK(q_b[35:0], 36'h0)
    apb_xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd & 32'h3c, 32'h04)
    done("reset");
    // single-port table, outputs registered
    foreach (rows[i]) op(rq(1'b1, 1'b0, rows[i].addr, rows[i].wd), '0, 0);
    foreach (rows[i]) begin
      op(rq(1'b0, 1'b1, rows[i].addr, 36'h0), '0, 2);
      `CHK(q_a[35:0], rows[i].exp)
    end
    done("table");
    // written word shows on q after the next edge when registered
    op(rq(1'b1, 1'b0, 16'h0030, 36'h5a5a5a5a5), '0, 2);
    `CHK(q_a[35:0], 36'h5a5a5a5a5)
    // output clear
    @(posedge clk_i);
    outclr <= 1'b1;
    @(posedge clk_i);
    outclr <= 1'b0;
    #1;
    `CHK(q_a[35:0], 36'h0)
    done("single_port");
    // bypassed output: data one cycle earlier, straight after capture
    apb_xfer(1'b1, CFG_ADDR, 32'h004);
    apb_xfer(1'b0, CFG_ADDR, 32'h0);
    `CHK(rd, 32'h004)
    op(rq(1'b0, 1'b1, 16'h007f, 36'h0), '0, 1);
    `CHK(q_a[35:0], 36'hfedcba987)
    // unregistered single-port write shows the word straight away
    op(rq(1'b1, 1'b0, 16'h0031, 36'h0c3c3c3c3), '0, 1);
    `CHK(q_a[35:0], 36'h0c3c3c3c3)
    apb_xfer(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    done("bypass");
    // simple dual-port collision: old data, then undefined bits
    apb_xfer(1'b1, CFG_ADDR, 32'h011);
    op(rq(1'b1, 1'b0, 16'h0014, 36'h111111111), '0, 0);
    op(rq(1'b1, 1'b0, 16'h0014, 36'h222222222), rq(1'b0, 1'b1, 16'h0014, 36'h0), 2);
    `CHK(q_b[35:0], 36'h111111111)
    apb_xfer(1'b1, CFG_ADDR, 32'h001);
    op(rq(1'b1, 1'b0, 16'h0014, 36'h333333333), rq(1'b0, 1'b1, 16'h0014, 36'h0), 2);
    `CHK(q_b[35:0], UNDEF_WORD[35:0])
    op('0, rq(1'b0, 1'b1, 16'h0014, 36'h0), 2);
    `CHK(q_b[35:0], 36'h333333333)
    // collision flag is write-one-to-clear
    apb_xfer(1'b1, STAT_ADDR, 32'h1);
    apb_xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd & 32'h3, 32'h0)
    done("simple_dual");
    // mixed width: four 9-bit lanes written on a, one 36-bit word read on b
    apb_xfer(1'b1, CFG_ADDR, 32'h081);
    for (int l = 0; l < 4; l++) op(rq(1'b1, 1'b0, 16'(12 + l), 36'(9'h101 + l)), '0, 0);
    op('0, rq(1'b0, 1'b1, 16'h0003, 36'h0), 2);
    `CHK(q_b[35:0], {9'h104, 9'h103, 9'h102, 9'h101})
    done("mixed_width");
    // flow-through: address taken on the falling edge, data before the next rising edge
    apb_xfer(1'b1, CFG_ADDR, 32'h021);
    op('0, rq(1'b0, 1'b1, 16'h0000, 36'h0), 0);
    #10;
    `CHK(q_b[35:0], 36'h123456789)
    done("flow_through");
    // true dual-port: two writes together, then crossed reads together
    apb_xfer(1'b1, CFG_ADDR, 32'h003);
    apb_xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd & 32'h3c, 32'h34)
    op(rq(1'b1, 1'b0, 16'h000a, 36'h0abcabcab), rq(1'b1, 1'b0, 16'h000b, 36'h0dede0ded), 0);
    op(rq(1'b0, 1'b1, 16'h000b, 36'h0), rq(1'b0, 1'b1, 16'h000a, 36'h0), 2);
    `CHK(q_a[35:0], 36'h0dede0ded)
    `CHK(q_b[35:0], 36'h0abcabcab)
    // rom phase: writes held off, contents stay
    hold = 1'b1;
    op(rq(1'b1, 1'b0, 16'h000a, 36'h0), '0, 0);
    hold = 1'b0;
    op(rq(1'b0, 1'b1, 16'h000a, 36'h0), '0, 2);
    `CHK(q_a[35:0], 36'h0abcabcab)
    // input clear drops a write already sitting at the block's inputs
    @(posedge clk_i);
    cmd_a <= rq(1'b1, 1'b0, 16'h000a, 36'h0);
    @(posedge clk_i);
    cmd_a <= '0;
    inclr <= 1'b1;
    @(posedge clk_i);
    inclr <= 1'b0;
    op(rq(1'b0, 1'b1, 16'h000a, 36'h0), '0, 2);
    `CHK(q_a[35:0], 36'h0abcabcab)
    done("true_dual");
    // two independent single-port memories sharing one block
    apb_xfer(1'b1, CFG_ADDR, 32'h002);
    op(rq(1'b1, 1'b0, 16'h0005, 36'h0c0c0c0c0), rq(1'b1, 1'b0, 16'h0005, 36'h0e0e0e0e0), 0);
    op(rq(1'b0, 1'b1, 16'h0005, 36'h0), rq(1'b0, 1'b1, 16'h0005, 36'h0), 2);
    `CHK(q_a[35:0], 36'h0c0c0c0c0)
    `CHK(q_b[35:0], 36'h0e0e0e0e0)
    done("dual_single");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
